//--- module_power_key_sequencer.sv
// Power on, power off and reset sequencer driven by level-held control pins.
// Assumes control inputs are synchronous to clk; the key pin pull-up is modelled here.
// Notes on behaviour
// - Key low 500 ms starts powered-off module
// - Power-on line high 500 ms starts module
// - Key low 2 s arms; release shuts down
// - Reset line low 370 ms resets module
// - Software shutdown equals key shutdown
// - Key active low, reads released when undriven
// - Card detect off at start, command enables
`timescale 1ns/10ps
module module_power_key_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int unsigned ON_CYC = ON_HOLD_CYC,
   parameter int unsigned OFF_CYC = OFF_HOLD_CYC,
   parameter int unsigned RST_CYC = RESET_HOLD_CYC,
   parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic power_key_input_n,
   input wire logic power_key_driven,
   input wire logic power_on_level_input,
   input wire logic reset_input_n,
   input wire logic sw_shutdown_cmd,
   input wire logic card_detect_enable_command,
   input wire logic card_detect_disable_command,
   input wire logic card_detect_polarity_high,
   input wire logic card_detect_input,
   output logic module_on_r,
   output logic module_reset_r,
   output logic shutdown_done_r,
   output logic supply_stable_r,
   output logic card_detect_enabled_r,
   output logic card_present_r
);
   pwr_state_t state_r;
   pwr_state_t state_nxt;
   logic [CNT_W-1:0] key_cnt_r;
   logic [CNT_W-1:0] pon_cnt_r;
   logic [CNT_W-1:0] rst_cnt_r;
   logic [CNT_W-1:0] settle_cnt_r;
   logic [CNT_W-1:0] pulse_cnt_r;
   logic key_low;
   logic key_start;
   logic pon_start;
   logic key_arm;
   logic rst_hit;
   logic start_ok;

   // Saturating hold counter: counts while active, clears on release
   function automatic logic [CNT_W-1:0] hold_next(input logic act, input logic [CNT_W-1:0] c,
                                                  input logic [CNT_W-1:0] lim);
      if (!act) begin
         hold_next = '0;
      end else if (c >= lim) begin
         hold_next = c;
      end else begin
         hold_next = c + 1'b1;
      end
   endfunction

   // Undriven key reads released
   assign key_low = power_key_driven & ~power_key_input_n;

   // Hold-time qualifiers; a short assertion never reaches its limit
   assign key_start = (key_cnt_r >= CNT_W'(ON_CYC));
   assign key_arm = (key_cnt_r >= CNT_W'(OFF_CYC));
   assign pon_start = (pon_cnt_r >= CNT_W'(ON_CYC));
   assign rst_hit = (rst_cnt_r >= CNT_W'(RST_CYC));
   // A qualified start seen while off, watched by the start assertion
   assign start_ok = (state_r == ST_OFF) && (key_start || pon_start);

   // Hold counters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         key_cnt_r <= '0;
         pon_cnt_r <= '0;
         rst_cnt_r <= '0;
      end else begin
         key_cnt_r <= hold_next(key_low, key_cnt_r, CNT_W'(OFF_CYC));
         pon_cnt_r <= hold_next(power_on_level_input, pon_cnt_r, CNT_W'(ON_CYC));
         rst_cnt_r <= hold_next(~reset_input_n & module_on_r, rst_cnt_r, CNT_W'(RST_CYC));
      end
   end

   // Supply settle tracker for the outside party
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         settle_cnt_r <= '0;
         supply_stable_r <= 1'b0;
      end else begin
         settle_cnt_r <= hold_next(1'b1, settle_cnt_r, CNT_W'(SETTLE_CYC));
         supply_stable_r <= (settle_cnt_r >= CNT_W'(SETTLE_CYC));
      end
   end

   // Next-state decode
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: begin
            if (key_start || pon_start) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (rst_hit) begin
               state_nxt = ST_RESET;
            end else if (sw_shutdown_cmd) begin
               state_nxt = ST_SHUTDOWN;
            end else if (key_arm) begin
               state_nxt = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!key_low) begin
               state_nxt = ST_SHUTDOWN;
            end
         end
         ST_SHUTDOWN: begin
            state_nxt = ST_OFF;
         end
         ST_RESET: begin
            if (pulse_cnt_r >= CNT_W'(RESET_PULSE_CYC) && reset_input_n) begin
               state_nxt = ST_RUN;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Reset pulse length counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_cnt_r <= '0;
      end else begin
         pulse_cnt_r <= hold_next(state_nxt == ST_RESET, pulse_cnt_r, CNT_W'(RESET_PULSE_CYC));
      end
   end

   // Outputs; shutdown_done marks when supply may be cut
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         module_on_r <= 1'b0;
         module_reset_r <= 1'b0;
         shutdown_done_r <= 1'b0;
      end else begin
         module_on_r <= (state_nxt != ST_OFF);
         module_reset_r <= (state_nxt == ST_RESET);
         if (state_r == ST_SHUTDOWN) begin
            shutdown_done_r <= 1'b1;
         end else if (state_nxt != ST_OFF) begin
            shutdown_done_r <= 1'b0;
         end
      end
   end

   // Card detect: disabled at each start-up, enabled by command
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         card_detect_enabled_r <= 1'b0;
         card_present_r <= 1'b0;
      end else begin
         if (state_r == ST_OFF || state_nxt == ST_OFF || card_detect_disable_command) begin
            card_detect_enabled_r <= 1'b0;
         end else if (card_detect_enable_command) begin
            card_detect_enabled_r <= 1'b1;
         end
         card_present_r <= card_detect_enabled_r &
                           (card_detect_input == card_detect_polarity_high);
      end
   end

   // Assertions
   a_start_key_hold: assert property (@(posedge clk) disable iff (!nrst)
      $rose(module_on_r) |-> $past(start_ok))
      else $error("start without qualified hold");
   a_short_ignored: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == ST_OFF && !key_start && !pon_start) |=> state_r == ST_OFF)
      else $error("short hold changed state");
   a_pon_start: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == ST_OFF && pon_start) |=> state_r == ST_RUN)
      else $error("power-on hold did not start");
   a_armed_waits: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == ST_ARMED && key_low) |=> state_r == ST_ARMED)
      else $error("shutdown before key release");
   a_release_shuts: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == ST_ARMED && !key_low) |=> state_r == ST_SHUTDOWN ##1 !module_on_r)
      else $error("release did not shut down");
   a_reset_hold: assert property (@(posedge clk) disable iff (!nrst)
      $rose(module_reset_r) |-> $past(rst_hit))
      else $error("reset without 370 ms hold");
   a_sw_shutdown: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == ST_RUN && sw_shutdown_cmd && !rst_hit) |=> ##1 (!module_on_r && shutdown_done_r))
      else $error("software shutdown failed");
   a_key_pullup: assert property (@(posedge clk) disable iff (!nrst)
      !power_key_driven |=> key_cnt_r == '0)
      else $error("undriven key counted");
   a_card_off_start: assert property (@(posedge clk) disable iff (!nrst)
      $rose(module_on_r) |-> !card_detect_enabled_r)
      else $error("card detect enabled at start");
   c_key_on: cover property (@(posedge clk) disable iff (!nrst) state_r == ST_OFF ##1 state_r == ST_RUN);
   c_key_off: cover property (@(posedge clk) disable iff (!nrst) state_r == ST_ARMED ##1 state_r == ST_SHUTDOWN);
   c_reset: cover property (@(posedge clk) disable iff (!nrst) state_r == ST_RESET ##1 state_r == ST_RUN);
   c_card: cover property (@(posedge clk) disable iff (!nrst) card_present_r);
   // Software shutdown reaching the supply-cut point
   c_sw_off: cover property (@(posedge clk) disable iff (!nrst) state_r == ST_RUN && sw_shutdown_cmd ##2 shutdown_done_r);
endmodule

//--- pwr_seq_pkg.sv
// Constants for the power key sequencer: hold times, cycle counts, states.
// Assumes a single 40 MHz clock domain.
package pwr_seq_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ON_HOLD_MS = 500;
   localparam int unsigned OFF_HOLD_MS = 2000;
   localparam int unsigned RESET_HOLD_MS = 370;
   localparam int unsigned SUPPLY_SETTLE_MS = 30;
   // Least times convert to cycles as ms times whole cycles per ms
   localparam int unsigned ON_HOLD_CYC = (ON_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned OFF_HOLD_CYC = (OFF_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_MS * (CLK_HZ / 1000));
   localparam int unsigned CNT_W = 27;
   localparam int unsigned RESET_PULSE_CYC = 16;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_ARMED,
      ST_SHUTDOWN,
      ST_RESET
   } pwr_state_t;
endpackage

//--- host_pins.sv
// Host pin model: drives the key, power-on and reset lines of the sequencer.
// Assumes one clock; the key is open-drain and idles released.
`timescale 1ns/10ps
module host_pins (
   input wire logic clk,
   input wire logic supply_stable_r,
   output logic power_key_input_n,
   output logic power_key_driven,
   output logic power_on_level_input,
   output logic reset_input_n
);
   // Lines start released
   initial begin
      power_key_input_n = 1'b1;
      power_key_driven = 1'b0;
      power_on_level_input = 1'b0;
      reset_input_n = 1'b1;
   end
   // Hold one line active for n edges: 0 key, 1 power-on, 2 reset
   task automatic hold(input int which, input int n, input logic drv);
      int k;
      k = 0;
      while (supply_stable_r !== 1'b1 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      case (which)
         0: begin
            power_key_driven <= drv;
            power_key_input_n <= 1'b0;
         end
         1: power_on_level_input <= 1'b1;
         default: reset_input_n <= 1'b0;
      endcase
      repeat (n) @(posedge clk);
      // Key goes back high and undriven so no restart follows
      power_key_input_n <= 1'b1;
      power_key_driven <= 1'b0;
      power_on_level_input <= 1'b0;
      reset_input_n <= 1'b1;
      @(posedge clk);
   endtask
endmodule

//--- module_power_key_sequencer_bench.sv
// Testbench for the power key sequencer; notes queue checked by a watcher.
// Assumes the host pin model and shortened hold counts.
`timescale 1ns/10ps
module module_power_key_sequencer_bench;
   import pwr_seq_pkg::*;
   localparam int ON = 20, OFF = 40, RST = 15, SET = 5;
   logic clk = 1'b0, nrst = 1'b0, sw = 1'b0, cen = 1'b0, cdis = 1'b0, pol = 1'b1, cin = 1'b0, b;
   logic kn, kd, pon, rn, on, rs, dn, ss, ce, cp;
   logic [4:0] q[$];
   logic [4:0] last = 5'h00;
   int err_total = 0, cmp_count = 0, seed = 32'hFB3C;
   module_power_key_sequencer #(.ON_CYC(ON), .OFF_CYC(OFF), .RST_CYC(RST), .SETTLE_CYC(SET)) DUT (
      .clk(clk), .nrst(nrst), .power_key_input_n(kn), .power_key_driven(kd), .power_on_level_input(pon),
      .reset_input_n(rn), .sw_shutdown_cmd(sw), .card_detect_enable_command(cen),
      .card_detect_disable_command(cdis), .card_detect_polarity_high(pol), .card_detect_input(cin),
      .module_on_r(on), .module_reset_r(rs), .shutdown_done_r(dn), .supply_stable_r(ss),
      .card_detect_enabled_r(ce), .card_present_r(cp));
   host_pins P (.clk(clk), .supply_stable_r(ss), .power_key_input_n(kn), .power_key_driven(kd),
      .power_on_level_input(pon), .reset_input_n(rn));
   // Clock, 25 ns period
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Each output change must match the oldest note
   always @(posedge clk) begin
      #1;
      if ({on, rs, dn, ce, cp} !== last) begin
         cmp_count++;
         if (q.size() == 0 || q[0] !== {on, rs, dn, ce, cp}) begin
            $display("ERROR outputs expected %h seen %h", q.size() ? q[0] : last, {on, rs, dn, ce, cp});
            err_total++;
         end
         if (q.size() != 0)
            q.pop_front();
         last = {on, rs, dn, ce, cp};
      end
   end
   task automatic note(input logic [4:0] v);
      q.push_back(v);
   endtask
   // Bounded wait for all notes to be seen
   task automatic drain;
      int k;
      k = 0;
      while (q.size() != 0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (q.size() != 0) begin
         $display("ERROR pending notes expected %0d seen %0d", 0, q.size());
         err_total++;
         complete_run();
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("Checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      // Supply-stable flag rises one edge after the settle count is reached
      repeat (SET) @(posedge clk);
      #1;
      cmp_count++;
      if (ss !== 1'b0) begin
         $display("ERROR supply_stable expected %b seen %b", 1'b0, ss);
         err_total++;
      end
      @(posedge clk);
      #1;
      cmp_count++;
      if (ss !== 1'b1) begin
         $display("ERROR supply_stable expected %b seen %b", 1'b1, ss);
         err_total++;
      end
      @(posedge clk);
      P.hold(0, ON - 3, 1'b1);
      P.hold(0, ON + 4, 1'b0);
      P.hold(2, RST + 4, 1'b1);
      drain();
      note(5'h10);
      P.hold(0, ON + 3 + ($unsigned($random(seed)) % 4), 1'b1);
      drain();
      P.hold(2, RST - 3, 1'b1);
      note(5'h18);
      note(5'h10);
      P.hold(2, RST + 4, 1'b1);
      drain();
      P.hold(0, OFF - 5, 1'b1);
      b = 1'($random(seed));
      pol <= b;
      cin <= ~b;
      note(5'h12);
      cen <= 1'b1;
      @(posedge clk);
      cen <= 1'b0;
      drain();
      note(5'h13);
      cin <= b;
      drain();
      note(5'h12);
      cin <= ~b;
      drain();
      note(5'h10);
      cdis <= 1'b1;
      @(posedge clk);
      cdis <= 1'b0;
      drain();
      note(5'h04);
      P.hold(0, OFF + 3, 1'b1);
      drain();
      note(5'h10);
      P.hold(1, ON + 3, 1'b1);
      drain();
      note(5'h04);
      sw <= 1'b1;
      @(posedge clk);
      sw <= 1'b0;
      drain();
      complete_run();
   end
endmodule
